/* hdl/lowpower_bg_cal_scheduler.sv */
// Low-power background calibration scheduler with trim registers
//
// Our own choice: the APB interface to the registers.
`default_nettype none
module lowpower_bg_cal_scheduler #(
	parameter logic [7:0][40:0] SLEEP_CYC  =
		lpcal_pkg::SLEEP_CYC_DFLT,
	parameter logic [3:0][40:0] SETTLE_CYC =
		lpcal_pkg::SETTLE_CYC_DFLT
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [9:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Factory trim from fuse storage
	input  wire logic [7:0]  fuse_gain_code,
	input  wire logic [3:0]  fuse_bandgap_code,
	// Calibration trigger pin and engine handshake
	input  wire logic        cal_trigger_pin,
	input  wire logic        cal_done,
	output logic             cal_start,
	// Offline core control
	output logic             adc_sleep,
	output logic             cal_trigger_level,
	// Trim codes to the analog side
	output logic [7:0]       gain_trim_code,
	output logic [3:0]       bandgap_trim_code
);

	localparam int W = lpcal_pkg::CNT_W;

	// =========================================================
	// Reset release through two flip-flops
	logic rst_meta_r;
	logic rst_n_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// =========================================================
	// Module state
	typedef struct packed {
		lpcal_pkg::lp_ctrl_s lp_ctrl;
		logic [7:0]          gain_adj;
		logic [7:0]          ref_adj;
		logic [7:0]          pin_cfg;
		logic [7:0]          soft_trig;
		logic                bgcal_en;
		logic                fuse_loaded;
		logic                pin_meta;
		logic                pin_sync;
		logic [31:0]         rdata;
		lpcal_pkg::sched_e   sched;
		logic                cal_start;
		logic                adc_sleep;
		logic                trig_level;
	} state_s;

	state_s s_r;
	state_s s_nxt;

	// =========================================================
	// Timer shared by sleep and settle intervals
	logic         tmr_start;
	logic         tmr_stop;
	logic [W-1:0] tmr_load;
	logic         tmr_busy;
	logic         tmr_done;

	interval_timer #(
		.W (W)
	) u_timer (
		.clk      (clk),
		.rst_n    (rst_n_r),
		.start    (tmr_start),
		.stop     (tmr_stop),
		.load_val (tmr_load),
		.busy     (tmr_busy),
		.done     (tmr_done)
	);

	// =========================================================
	// Derived controls
	logic         lp_active;
	logic         auto_mode;
	logic         trig_now;
	logic [W-1:0] sleep_cnt;
	logic [W-1:0] settle_cnt;

	// Low-power mode only counts while background cal runs
	assign lp_active = s_r.bgcal_en &
		s_r.lp_ctrl.lowpower_cal_enable;
	assign auto_mode = ~s_r.lp_ctrl.trigger_sleep_mode;

	// Trigger from pin or software bit
	assign trig_now = s_r.pin_cfg[0] ? s_r.pin_sync
		: s_r.soft_trig[0];

	assign sleep_cnt =
		SLEEP_CYC[s_r.lp_ctrl.sleep_interval_sel];
	assign settle_cnt =
		SETTLE_CYC[s_r.lp_ctrl.settle_interval_sel];

	// =========================================================
	// APB decode
	logic       setup_ph;
	logic       access_ph;
	logic [6:0] idx;
	logic       hit;
	logic [7:0] rd_byte;
	logic       wr_en;

	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	assign idx       = paddr[8:2];

	always_comb begin
		hit     = (paddr[1:0] == 2'b00) & ~paddr[9];
		rd_byte = 8'h00;
		case (idx)
			lpcal_pkg::IDX_BGCAL_CTRL: begin
				rd_byte = {7'h00, s_r.bgcal_en};
			end
			lpcal_pkg::IDX_SCHED_STAT: begin
				rd_byte = {1'b0, s_r.trig_level, tmr_busy,
					s_r.adc_sleep, s_r.sched};
			end
			lpcal_pkg::IDX_PIN_CFG: begin
				rd_byte = s_r.pin_cfg;
			end
			lpcal_pkg::IDX_SOFT_TRIG: begin
				rd_byte = s_r.soft_trig;
			end
			lpcal_pkg::IDX_LP_CTRL: begin
				rd_byte = s_r.lp_ctrl;
			end
			lpcal_pkg::IDX_GAIN_ADJ: begin
				rd_byte = s_r.gain_adj;
			end
			lpcal_pkg::IDX_REF_ADJ: begin
				rd_byte = s_r.ref_adj;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	assign wr_en = access_ph & pwrite & hit & pstrb[0];

	// =========================================================
	// Next state
	always_comb begin
		s_nxt     = s_r;
		tmr_start = 1'b0;
		tmr_stop  = ~lp_active;
		tmr_load  = sleep_cnt;

		// Pin passes two flip-flops
		s_nxt.pin_meta = cal_trigger_pin;
		s_nxt.pin_sync = s_r.pin_meta;

		// Read data is caught in the setup cycle
		if (setup_ph && !pwrite) begin
			// Unmapped or unaligned reads return zero
			s_nxt.rdata = {24'h00_0000, hit ? rd_byte : 8'h00};
		end

		// Register writes
		if (wr_en) begin
			case (idx)
				lpcal_pkg::IDX_BGCAL_CTRL: begin
					s_nxt.bgcal_en = pwdata[0];
				end
				lpcal_pkg::IDX_PIN_CFG: begin
					s_nxt.pin_cfg = pwdata[7:0];
				end
				lpcal_pkg::IDX_SOFT_TRIG: begin
					s_nxt.soft_trig = pwdata[7:0];
				end
				lpcal_pkg::IDX_LP_CTRL: begin
					s_nxt.lp_ctrl = pwdata[7:0];
				end
				lpcal_pkg::IDX_GAIN_ADJ: begin
					s_nxt.gain_adj = pwdata[7:0];
				end
				lpcal_pkg::IDX_REF_ADJ: begin
					s_nxt.ref_adj = pwdata[7:0];
				end
				default: begin
				end
			endcase
		end

		// Factory trim captured once after reset release
		if (!s_r.fuse_loaded) begin
			s_nxt.gain_adj    = fuse_gain_code;
			s_nxt.ref_adj     = {4'h0, fuse_bandgap_code};
			s_nxt.fuse_loaded = 1'b1;
		end

		// Scheduler
		s_nxt.cal_start = 1'b0;
		case (s_r.sched)
			lpcal_pkg::ST_IDLE: begin
				if (lp_active) begin
					s_nxt.sched = lpcal_pkg::ST_SLEEP;
					tmr_start   = auto_mode;
				end
			end
			lpcal_pkg::ST_SLEEP: begin
				if (!lp_active) begin
					s_nxt.sched = lpcal_pkg::ST_IDLE;
				end else if (!auto_mode) begin
					// Trigger high keeps the core asleep
					if (!trig_now) begin
						s_nxt.sched = lpcal_pkg::ST_SETTLE;
						tmr_start   = 1'b1;
						tmr_load    = settle_cnt;
					end
				end else if (tmr_done) begin
					s_nxt.sched = lpcal_pkg::ST_SETTLE;
					tmr_start   = 1'b1;
					tmr_load    = settle_cnt;
				end else if (!tmr_busy) begin
					// Entered from trigger mode: start timing
					tmr_start = 1'b1;
				end
			end
			lpcal_pkg::ST_SETTLE: begin
				if (!lp_active) begin
					s_nxt.sched = lpcal_pkg::ST_IDLE;
				end else if (tmr_done) begin
					s_nxt.sched     = lpcal_pkg::ST_CAL;
					s_nxt.cal_start = 1'b1;
				end
			end
			lpcal_pkg::ST_CAL: begin
				if (!lp_active) begin
					s_nxt.sched = lpcal_pkg::ST_IDLE;
				end else if (cal_done) begin
					s_nxt.sched = lpcal_pkg::ST_SLEEP;
					tmr_start   = auto_mode;
				end
			end
			default: begin
				s_nxt.sched = lpcal_pkg::ST_IDLE;
			end
		endcase

		s_nxt.adc_sleep  = (s_nxt.sched == lpcal_pkg::ST_SLEEP);
		s_nxt.trig_level = trig_now;
	end

	// =========================================================
	// State register
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			s_r.lp_ctrl     <= lpcal_pkg::RST_LP_CTRL;
			s_r.gain_adj    <= lpcal_pkg::RST_GAIN_ADJ;
			s_r.ref_adj     <= lpcal_pkg::RST_REF_ADJ;
			s_r.pin_cfg     <= lpcal_pkg::RST_PIN_CFG;
			s_r.soft_trig   <= lpcal_pkg::RST_SOFT_TRIG;
			s_r.bgcal_en    <= lpcal_pkg::RST_BGCAL_EN;
			s_r.fuse_loaded <= 1'b0;
			s_r.pin_meta    <= 1'b0;
			s_r.pin_sync    <= 1'b0;
			s_r.rdata       <= 32'h0000_0000;
			s_r.sched       <= lpcal_pkg::ST_IDLE;
			s_r.cal_start   <= 1'b0;
			s_r.adc_sleep   <= 1'b0;
			s_r.trig_level  <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// =========================================================
	// Outputs
	assign pready            = 1'b1;
	assign pslverr           = access_ph & ~hit;
	assign prdata            = s_r.rdata;
	assign cal_start         = s_r.cal_start;
	assign adc_sleep         = s_r.adc_sleep;
	assign cal_trigger_level = s_r.trig_level;
	assign gain_trim_code    = s_r.gain_adj;
	assign bandgap_trim_code = s_r.ref_adj[3:0];

endmodule
`default_nettype wire

/* hdl/lpcal_pkg.sv */
// Constants and types for the low-power calibration scheduler
`default_nettype none
package lpcal_pkg;

	// =========================================================
	// Register indices (byte address is four times the index)
	localparam logic [6:0] IDX_BGCAL_CTRL = 7'h60;
	localparam logic [6:0] IDX_SCHED_STAT = 7'h61;
	localparam logic [6:0] IDX_PIN_CFG    = 7'h6b;
	localparam logic [6:0] IDX_SOFT_TRIG  = 7'h6c;
	localparam logic [6:0] IDX_LP_CTRL    = 7'h6e;
	localparam logic [6:0] IDX_GAIN_ADJ   = 7'h7a;
	localparam logic [6:0] IDX_REF_ADJ    = 7'h7c;

	// =========================================================
	// Reset values
	localparam logic [7:0] RST_LP_CTRL    = 8'h88;
	localparam logic [7:0] RST_PIN_CFG    = 8'h00;
	localparam logic [7:0] RST_SOFT_TRIG  = 8'h01;
	localparam logic [7:0] RST_GAIN_ADJ   = 8'h00;
	localparam logic [7:0] RST_REF_ADJ    = 8'h00;
	localparam logic       RST_BGCAL_EN   = 1'b0;

	// =========================================================
	// Interval counts in sample clock periods
	localparam int         CNT_W = 41;
	localparam logic [7:0][40:0] SLEEP_CYC_DFLT = {
		41'h100_0000_0080, 41'h020_0000_0080,
		41'h004_0000_0080, 41'h000_8000_0080,
		41'h000_1000_0080, 41'h000_0200_0080,
		41'h000_0040_0080, 41'h000_0000_0480};
	localparam logic [3:0][40:0] SETTLE_CYC_DFLT = {
		41'h000_8000_0080, 41'h000_1000_0080,
		41'h000_0200_0080, 41'h000_0000_0480};

	// =========================================================
	// Types
	typedef struct packed {
		logic [2:0] sleep_interval_sel;
		logic [1:0] settle_interval_sel;
		logic       reserved_b2;
		logic       trigger_sleep_mode;
		logic       lowpower_cal_enable;
	} lp_ctrl_s;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_SLEEP  = 4'b0010,
		ST_SETTLE = 4'b0100,
		ST_CAL    = 4'b1000
	} sched_e;

endpackage
`default_nettype wire

/* hdl/interval_timer.sv */
// Loadable down-counter that pulses done after a set number of cycles
`default_nettype none
module interval_timer #(
	parameter int W = 41
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Control
	input  wire logic         start,
	input  wire logic         stop,
	input  wire logic [W-1:0] load_val,
	// Status
	output logic              busy,
	output logic              done
);

	typedef struct packed {
		logic         busy;
		logic [W-1:0] cnt;
	} tmr_s;

	tmr_s s_r;
	tmr_s s_nxt;

	// =========================================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		if (stop) begin
			s_nxt.busy = 1'b0;
			s_nxt.cnt  = '0;
		end else if (start) begin
			s_nxt.busy = 1'b1;
			s_nxt.cnt  = load_val - W'(1);
		end else if (s_r.busy) begin
			if (s_r.cnt == '0) begin
				s_nxt.busy = 1'b0;
			end else begin
				s_nxt.cnt = s_r.cnt - W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Done on the last counted cycle
	assign busy = s_r.busy;
	assign done = s_r.busy & (s_r.cnt == '0);

endmodule
`default_nettype wire

/* dv/lowpower_bg_cal_scheduler_monitor.sv */
// Port checker for the low-power calibration scheduler
`default_nettype none
module lpcal_monitor #(
	parameter logic [7:0][40:0] SLEEP_CYC  = lpcal_pkg::SLEEP_CYC_DFLT,
	parameter logic [3:0][40:0] SETTLE_CYC = lpcal_pkg::SETTLE_CYC_DFLT
) (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [9:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Scheduler and trims
	input wire logic        cal_start,
	input wire logic        adc_sleep,
	input wire logic [7:0]  gain_trim_code,
	input wire logic [3:0]  bandgap_trim_code
);
	logic acc;
	logic wr;
	assign acc = psel & penable;
	assign wr = acc & pwrite & pstrb[0];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// ==========================================================
	// Assertions
	gain_write_a: assert property (
		wr && paddr == 10'h1e8 |=> gain_trim_code == $past(pwdata[7:0]))
		else $error("gain trim missed write");
	ref_write_a: assert property (
		wr && paddr == 10'h1f0 |=> bandgap_trim_code == $past(pwdata[3:0]))
		else $error("band-gap trim missed write");
	start_pulse_a: assert property (cal_start |=> !cal_start)
		else $error("start longer than one cycle");
	cal_awake_a: assert property (cal_start |-> !adc_sleep)
		else $error("calibration started while asleep");
	disable_idle_a: assert property (
		wr && paddr == 10'h1b8 && !pwdata[0] |-> ##3 !adc_sleep)
		else $error("core still asleep after disable");
	unmapped_err_a: assert property (acc && paddr[9] |-> pslverr)
		else $error("no error on unmapped access");
	err_scope_a: assert property (pslverr |-> acc)
		else $error("error outside access phase");
	unmapped_data_a: assert property (
		acc && !pwrite && paddr[9] |-> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	cover property (cal_start);
	cover property ($fell(adc_sleep));
	cover property (acc && pslverr);
endmodule

bind lowpower_bg_cal_scheduler lpcal_monitor #(
	.SLEEP_CYC(SLEEP_CYC), .SETTLE_CYC(SETTLE_CYC)
) i_mon (
	.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pslverr(pslverr), .cal_start(cal_start),
	.adc_sleep(adc_sleep), .gain_trim_code(gain_trim_code),
	.bandgap_trim_code(bandgap_trim_code));
`default_nettype wire

/* dv/lowpower_bg_cal_scheduler_tb.sv */
// Self-checking bench for the low-power calibration scheduler
`default_nettype none
module lowpower_bg_cal_scheduler_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0][40:0] SLP = {41'd48, 41'd44, 41'd40,
		41'd36, 41'd32, 41'd28, 41'd24, 41'd20};
	localparam logic [3:0][40:0] STL = {41'd32, 41'd28, 41'd24, 41'd20};
	logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [9:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0]  pstrb = 4'hf, bgap;
	logic [7:0]  gain;
	logic        pin = 0, cal_done = 0, pready, pslverr, err;
	logic        cal_start, adc_sleep, lvl;
	int          err_total = 0, tests_run = 0, n;
	logic [1:0]  sc;

	lowpower_bg_cal_scheduler #(.SLEEP_CYC(SLP), .SETTLE_CYC(STL)) i_dut (
		.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.fuse_gain_code(8'h5a), .fuse_bandgap_code(4'h9),
		.cal_trigger_pin(pin), .cal_done(cal_done), .cal_start(cal_start),
		.adc_sleep(adc_sleep), .cal_trigger_level(lvl),
		.gain_trim_code(gain), .bandgap_trim_code(bgap));
	always #2 clk = ~clk;

	task automatic chk(input logic [31:0] got, exp, input string m);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s %h/%h", $time, m, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [9:0] a,
		input logic [7:0] d);
		int k;
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) begin
			err_total++;
			$display("wrong value at %0t: no ready", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rchk(input logic [9:0] a, input logic [7:0] e,
		input string m);
		xfer(0, a, 0);
		chk(rd, {24'h0, e}, m);
	endtask
	// Count edges until cal_start or adc_sleep shows v
	task automatic wsig(input bit st, input logic v);
		n = 0;
		while ((st ? cal_start : adc_sleep) !== v && n < 400) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#80000;
		err_total++;
		close_out();
	end

	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1;
		repeat (4) @(posedge clk);
		rchk(10'h1b8, 8'h88, "lp rst");
		rchk(10'h1b0, 8'h01, "soft rst");
		rchk(10'h184, 8'h41, "status rst");
		chk(lvl, 1, "lvl rst");
		rchk(10'h1e8, 8'h5a, "gain fuse");
		rchk(10'h1f0, 8'h09, "ref fuse");
		xfer(1, 10'h1e8, 8'ha5);
		rchk(10'h1e8, 8'ha5, "gain rw");
		chk(gain, 8'ha5, "gain out");
		xfer(1, 10'h1f0, 8'h0c);
		rchk(10'h1f0, 8'h0c, "ref rw");
		chk(bgap, 4'hc, "ref out");
		xfer(0, 10'h200, 0);
		chk({rd[7:0], err}, 9'h001, "unmapped");
		xfer(1, 10'h1b0, 8'h00);
		repeat (6) @(posedge clk);
		chk(lvl, 0, "soft low");
		pin <= 1;
		xfer(1, 10'h1ac, 8'h01);
		repeat (6) @(posedge clk);
		chk(lvl, 1, "pin high");
		xfer(1, 10'h1b0, 8'h01);
		pin <= 0;
		repeat (6) @(posedge clk);
		chk(lvl, 0, "soft ignored");
		xfer(1, 10'h1b8, 8'h89);
		repeat (100) @(posedge clk);
		chk(adc_sleep, 0, "bg gate");
		xfer(1, 10'h1b8, 8'h00);
		xfer(1, 10'h180, 8'h01);
		for (int c = 0; c < 8; c++) begin
			sc = (c[1:0] == 2'd0) ? 2'd1 : c[1:0];
			xfer(1, 10'h1b8, {c[2:0], sc, 3'b001});
			wsig(0, 1);
			wsig(0, 0);
			chk(n >= SLP[c] && n <= SLP[c] + 3, 1, "sleep");
			wsig(1, 1);
			chk(n >= STL[sc] && n <= STL[sc] + 3, 1, "settle");
			cal_done <= 1;
			@(posedge clk);
			cal_done <= 0;
			wsig(0, 1);
			chk(n <= 3, 1, "resleep");
			xfer(1, 10'h1b8, 8'h00);
		end
		pin <= 1;
		xfer(1, 10'h1b8, 8'h8b);
		wsig(0, 1);
		repeat (100) @(posedge clk);
		chk(adc_sleep, 1, "trig sleep");
		pin <= 0;
		wsig(1, 1);
		chk(n <= 60, 1, "trig wake");
		cal_done <= 1;
		pin <= 1;
		@(posedge clk);
		cal_done <= 0;
		wsig(0, 1);
		chk(n <= 3, 1, "trig resleep");
		close_out();
	end
endmodule
`default_nettype wire
